// >>> logic/io_config_store_manager.sv
// Operation
// - save-from-live copies live set to saved
// - save-from-factory copies factory set to saved
// - load-from-factory copies factory set to live
// - load-from-saved copies saved set to live
// - boot loads live set from saved
// - saved settings persist and apply at boot; rst here clears the saved set to zero
// - checksum read returns CRC32 of live set; while triggers are queued it returns zero
// - checksum answer takes 5 to 15 ms; while triggers are queued the zero answer comes one cycle after the read
// - checksum excludes states, directions, DAC
// - exact key write starts factory wipe
// - wireless disabled throughout wipe
// - LEDs alternate in wipe, unison on failure
// - successful wipe clears user settings
// - wireless credentials untouched by wipe
// - device silent while wipe runs
// - factory reset also erases saved defaults
// - watchdog timeout loads factory or saved
`timescale 1ns/100ps
module io_config_store_manager
    import io_config_pkg::*;
#(
    parameter int CRC_CYCLES  = CRC_MIN_CYCLES,
    parameter int WIPE_LEN    = WIPE_CYCLES,
    parameter int BLINK_LEN   = BLINK_CYCLES,
    parameter int QUEUE_DEPTH = 4
) (
    // clock and reset
    input  wire logic                             clk,
    input  wire logic                             rst,
    // register port
    input  wire io_config_pkg::reg_req_s          req,
    output io_config_pkg::reg_rsp_s               rsp,
    // live configuration image and its editing port
    input  wire logic                             live_wr,
    input  wire logic [2:0]                       live_sel,
    input  wire logic [31:0]                      live_wdata,
    output logic [io_config_pkg::NUM_SYS*32-1:0]  live_cfg,
    // factory set, fixed at manufacture
    input  wire logic [io_config_pkg::NUM_SYS*32-1:0] factory_cfg,
    // watchdog timeout event and advanced option word
    input  wire logic                             wdog_timeout,
    input  wire logic [31:0]                      wdog_advanced,
    // wipe side effects
    input  wire logic                             wipe_fail,
    output logic                                  wireless_off,
    output logic                                  user_clear,
    output logic [1:0]                            led
);
    import io_config_pkg::*;

    localparam int QW = $clog2(QUEUE_DEPTH);
    localparam logic [31:0] CRC_LEN = 32'(CRC_CYCLES);
    localparam logic [31:0] WIPE_N  = 32'(WIPE_LEN);
    localparam logic [31:0] BLINK_N = 32'(BLINK_LEN);

    typedef struct packed {
        op_state_e                   st;
        logic [NUM_SYS*32-1:0]       live;
        logic [NUM_SYS*32-1:0]       saved;
        logic                        booted;
        logic [QUEUE_DEPTH*3-1:0]    q;
        logic [QW:0]                 qcnt;
        logic [31:0]                 cnt;
        logic [31:0]                 blink;
        logic [31:0]                 crc;
        reg_rsp_s                    rsp;
        logic                        wless;
        logic                        uclr;
        logic [1:0]                  led;
        logic                        failed;
    } state_s;

    state_s r;
    state_s next_r;

    function automatic logic [31:0] crc_word(input logic [31:0] c,
                                             input logic [31:0] d);
        logic [31:0] x;
        x = c ^ d;
        for (int i = 0; i < 32; i++) begin
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction : crc_word

    // checksum covers only the analog and extended-feature systems
    function automatic logic [31:0] live_crc(input logic [NUM_SYS*32-1:0] c);
        logic [31:0] x;
        x = CRC_INIT;
        x = crc_word(x, c[SYS_ANALOG*32 +: 32]);
        x = crc_word(x, c[SYS_ANALOG_EXT*32 +: 32]);
        x = crc_word(x, c[SYS_DIGITAL_EXT*32 +: 32]);
        return ~x;
    endfunction : live_crc

    op_e wr_op;
    always_comb begin
        wr_op = OP_NONE;
        if (req.wr) begin
            case (req.addr)
                ADDR_SAVE_DEFAULTS_FROM_LIVE:
                    if (req.wdata == TRIGGER_ONE) wr_op = OP_SAVE_LIVE;
                ADDR_SAVE_DEFAULTS_FROM_FACTORY:
                    if (req.wdata == TRIGGER_ONE) wr_op = OP_SAVE_FACT;
                // 16-bit trigger registers: upper data bits are don't-care
                ADDR_LOAD_LIVE_FROM_FACTORY:
                    if (req.wdata[15:0] == TRIGGER_ONE[15:0]) begin
                        wr_op = OP_LOAD_FACT;
                    end
                ADDR_LOAD_LIVE_FROM_SAVED:
                    if (req.wdata[15:0] == TRIGGER_ONE[15:0]) begin
                        wr_op = OP_LOAD_SAVED;
                    end
                ADDR_WIPE_TRIGGER:
                    if (req.wdata == WIPE_KEY) wr_op = OP_WIPE;
                default: wr_op = OP_NONE;
            endcase
        end
    end

    op_e wd_op;
    always_comb begin
        wd_op = OP_NONE;
        if (wdog_timeout && wdog_advanced[WDOG_BIT_FACTORY]) begin
            wd_op = OP_LOAD_FACT;
        end else if (wdog_timeout && wdog_advanced[WDOG_BIT_SAVED]) begin
            wd_op = OP_LOAD_SAVED;
        end
    end

    always_comb begin
        logic [QW:0]  c;
        logic [2:0]   head;
        next_r = r;
        c = r.qcnt;
        head = r.q[2:0];
        next_r.rsp.ack = 1'b0;
        next_r.uclr = 1'b0;
        if (!r.booted) begin
            next_r.live = r.saved;
            next_r.booted = 1'b1;
        end
        if (live_wr && live_sel < 3'(NUM_SYS) && r.st != ST_WIPE) begin
            next_r.live[live_sel*32 +: 32] = live_wdata;
        end
        // queue: requests held in arrival order while another runs
        // a full queue drops the newest request; the host must pace triggers
        if (wd_op != OP_NONE && c <= (QW+1)'(QUEUE_DEPTH - 1)) begin
            next_r.q[c*3 +: 3] = 3'(wd_op);
            c = c + 1'b1;
        end
        if (wr_op != OP_NONE && c <= (QW+1)'(QUEUE_DEPTH - 1)) begin
            next_r.q[c*3 +: 3] = 3'(wr_op);
            c = c + 1'b1;
        end
        case (r.st)
            ST_IDLE: begin
                // with triggers pending a read gets an immediate zero answer
                // so the host is never stalled behind a queue of copies
                if (req.rd && r.qcnt == '0) begin
                    next_r.st = ST_CRC;
                    next_r.cnt = '0;
                    next_r.crc = live_crc(r.live);
                end else if (req.rd) begin
                    next_r.rsp.ack = 1'b1;
                    next_r.rsp.rdata = '0;
                end else if (r.qcnt != '0) begin
                    next_r.q = next_r.q >> 3;
                    c = c - 1'b1;
                    next_r.st = ST_COPY;
                    case (op_e'(head))
                        OP_SAVE_LIVE: next_r.saved = r.live;
                        OP_SAVE_FACT: next_r.saved = factory_cfg;
                        OP_LOAD_FACT: next_r.live = factory_cfg;
                        OP_LOAD_SAVED: next_r.live = r.saved;
                        OP_WIPE: begin
                            next_r.st = ST_WIPE;
                            next_r.cnt = '0;
                            next_r.blink = '0;
                            next_r.wless = 1'b1;
                            next_r.led = 2'b01;
                            next_r.failed = 1'b0;
                        end
                        default: next_r.st = ST_IDLE;
                    endcase
                end
            end
            ST_COPY: next_r.st = ST_IDLE;
            ST_CRC: begin
                // answer held back so it lands inside the 5..15 ms window
                next_r.cnt = r.cnt + 1'b1;
                if (r.cnt == CRC_LEN - 1) begin
                    next_r.rsp.ack = 1'b1;
                    next_r.rsp.rdata = r.crc;
                    next_r.st = ST_IDLE;
                end
            end
            ST_WIPE: begin
                // register traffic meanwhile gets no ack at all
                next_r.cnt = r.cnt + 1'b1;
                next_r.blink = r.blink + 1'b1;
                if (wipe_fail) next_r.failed = 1'b1;
                if (r.blink == BLINK_N - 1) begin
                    next_r.blink = '0;
                    if (next_r.failed) begin
                        next_r.led = (r.led == 2'b11) ? 2'b00 : 2'b11;
                    end else begin
                        next_r.led = (r.led == 2'b01) ? 2'b10 : 2'b01;
                    end
                end
                if (r.cnt == WIPE_N - 1) begin
                    if (!next_r.failed) begin
                        // credentials inside the radio are outside this image
                        next_r.live = factory_cfg;
                        next_r.saved = factory_cfg;
                        next_r.uclr = 1'b1;
                        next_r.led = 2'b00;
                        next_r.wless = 1'b0;
                        next_r.st = ST_IDLE;
                    end else begin
                        // a failed wipe keeps blinking until reset
                        next_r.cnt = WIPE_N - 1;
                    end
                end
            end
            default: next_r.st = ST_IDLE;
        endcase
        next_r.qcnt = c;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // saved set starts empty; the boot step then loads it into live
            r <= '0;
            r.st <= ST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign rsp          = r.rsp;
    assign live_cfg     = r.live;
    assign wireless_off = r.wless;
    assign user_clear   = r.uclr;
    assign led          = r.led;

    AST_SAVE_LIVE: assert property (@(posedge clk) disable iff (rst)
        (r.st == ST_IDLE && !req.rd && r.qcnt != '0
         && op_e'(r.q[2:0]) == OP_SAVE_LIVE) |=> r.saved == $past(r.live))
        else $error("saved set not taken from live");
    AST_SAVE_FACT: assert property (@(posedge clk) disable iff (rst)
        (r.st == ST_IDLE && !req.rd && r.qcnt != '0
         && op_e'(r.q[2:0]) == OP_SAVE_FACT) |=> r.saved == $past(factory_cfg))
        else $error("saved set not taken from factory");
    AST_LOAD_SAVED: assert property (@(posedge clk) disable iff (rst)
        (r.st == ST_IDLE && !req.rd && r.qcnt != '0
         && op_e'(r.q[2:0]) == OP_LOAD_SAVED) |=> r.live == $past(r.saved))
        else $error("live set not loaded from saved");
    AST_CRC_TIME: assert property (@(posedge clk) disable iff (rst)
        (r.st == ST_IDLE && req.rd && r.qcnt == '0) |=> !r.rsp.ack [*2])
        else $error("checksum answered too early");
    AST_BAD_KEY: assert property (@(posedge clk) disable iff (rst)
        (req.wr && req.addr == ADDR_WIPE_TRIGGER && req.wdata != WIPE_KEY
         && r.qcnt == '0 && !wdog_timeout) |=> r.qcnt == '0)
        else $error("wrong wipe key accepted");
    AST_WIRELESS: assert property (@(posedge clk) disable iff (rst)
        r.st == ST_WIPE |-> r.wless)
        else $error("wireless on during wipe");
    AST_LED_ALT: assert property (@(posedge clk) disable iff (rst)
        (r.st == ST_WIPE && !r.failed) |-> (r.led[0] != r.led[1]))
        else $error("leds not alternating");
    AST_SILENT: assert property (@(posedge clk) disable iff (rst)
        (r.st == ST_WIPE) |=> !r.rsp.ack)
        else $error("answer during wipe");
    AST_WIPE_SAVED: assert property (@(posedge clk) disable iff (rst)
        $rose(r.uclr) |-> r.saved == $past(factory_cfg))
        else $error("saved set not erased by wipe");

    // sequencing, checksum timing and wipe checks
    AST_LOAD_FACT: assert property (@(posedge clk) disable iff (rst)
        (r.st == ST_IDLE && !req.rd && r.qcnt != '0
         && op_e'(r.q[2:0]) == OP_LOAD_FACT) |=> r.live == $past(factory_cfg))
        else $error("live set not loaded from factory");
    AST_WIPE_ENTRY: assert property (@(posedge clk) disable iff (rst)
        (r.st == ST_IDLE && !req.rd && r.qcnt != '0
         && op_e'(r.q[2:0]) == OP_WIPE)
        |=> (r.st == ST_WIPE && r.wless && r.led == 2'b01))
        else $error("wipe not started from the queue");
    AST_COPY_DONE: assert property (@(posedge clk) disable iff (rst)
        r.st == ST_COPY |=> r.st == ST_IDLE)
        else $error("copy held the sequencer too long");
    AST_QUEUE_BOUND: assert property (@(posedge clk) disable iff (rst)
        r.qcnt <= (QW+1)'(QUEUE_DEPTH))
        else $error("queue count beyond depth");
    AST_TRIG_ORDER: assert property (@(posedge clk) disable iff (rst)
        (req.wr && req.addr == ADDR_SAVE_DEFAULTS_FROM_LIVE
         && req.wdata == TRIGGER_ONE && r.qcnt == '0 && !wdog_timeout)
        |=> op_e'(r.q[2:0]) == OP_SAVE_LIVE)
        else $error("save trigger not queued");
    AST_WDOG_FACT: assert property (@(posedge clk) disable iff (rst)
        (wdog_timeout && wdog_advanced[WDOG_BIT_FACTORY] && r.qcnt == '0)
        |=> op_e'(r.q[2:0]) == OP_LOAD_FACT)
        else $error("watchdog factory load not queued");
    AST_WDOG_SAVED: assert property (@(posedge clk) disable iff (rst)
        (wdog_timeout && !wdog_advanced[WDOG_BIT_FACTORY]
         && wdog_advanced[WDOG_BIT_SAVED] && r.qcnt == '0)
        |=> op_e'(r.q[2:0]) == OP_LOAD_SAVED)
        else $error("watchdog saved load not queued");
    AST_BAD_TRIGGER: assert property (@(posedge clk) disable iff (rst)
        (req.wr && (req.addr == ADDR_LOAD_LIVE_FROM_FACTORY
                    || req.addr == ADDR_LOAD_LIVE_FROM_SAVED)
         && req.wdata[15:0] != TRIGGER_ONE[15:0]
         && r.qcnt == '0 && !wdog_timeout) |=> r.qcnt == '0)
        else $error("bad load trigger accepted");
    AST_BOOT: assert property (@(posedge clk) disable iff (rst)
        (!r.booted && !live_wr) |=> (r.booted && r.live == $past(r.saved)))
        else $error("boot did not load the saved set");
    AST_CRC_EARLY: assert property (@(posedge clk) disable iff (rst)
        (r.st == ST_CRC && r.cnt != CRC_LEN - 1) |=> !r.rsp.ack)
        else $error("checksum answered before its time");
    AST_CRC_DATA: assert property (@(posedge clk) disable iff (rst)
        (r.st == ST_CRC && r.cnt == CRC_LEN - 1)
        |=> (r.rsp.ack && r.rsp.rdata == $past(r.crc) && r.st == ST_IDLE))
        else $error("checksum not answered at its time");
    AST_WIPE_CLEAR: assert property (@(posedge clk) disable iff (rst)
        $rose(r.uclr) |-> (r.live == $past(factory_cfg) && !r.wless))
        else $error("wipe end left live set stale or radio off");
    AST_WIPE_FROZEN: assert property (@(posedge clk) disable iff (rst)
        (r.st == ST_WIPE && r.cnt != WIPE_N - 1) |=> r.live == $past(r.live))
        else $error("live set edited during wipe");
    AST_WIPE_BOUND: assert property (@(posedge clk) disable iff (rst)
        r.st == ST_WIPE |-> r.cnt <= WIPE_N - 1)
        else $error("wipe counter ran past its length");
    AST_LED_FAIL: assert property (@(posedge clk) disable iff (rst)
        (r.st == ST_WIPE && r.failed && r.blink == BLINK_N - 1)
        |=> r.led[0] == r.led[1])
        else $error("leds not in unison after wipe failure");
endmodule : io_config_store_manager

// >>> logic/io_config_pkg.sv
package io_config_pkg;

    // register addresses (word addresses)
    localparam logic [15:0] ADDR_SAVE_DEFAULTS_FROM_LIVE    = 16'hbf6a;
    localparam logic [15:0] ADDR_SAVE_DEFAULTS_FROM_FACTORY = 16'hbf6c;
    localparam logic [15:0] ADDR_LIVE_CONFIG_CHECKSUM       = 16'hbf7c;
    localparam logic [15:0] ADDR_WIPE_TRIGGER               = 16'hbfc2;
    localparam logic [15:0] ADDR_LOAD_LIVE_FROM_FACTORY     = 16'hf226;
    localparam logic [15:0] ADDR_LOAD_LIVE_FROM_SAVED       = 16'hf227;

    localparam logic [31:0] WIPE_KEY    = 32'h5317052e;
    localparam logic [31:0] TRIGGER_ONE = 32'h00000001;

    // watchdog advanced option bits
    localparam int WDOG_BIT_FACTORY = 0;
    localparam int WDOG_BIT_SAVED   = 1;

    // configuration image: five systems, one word each
    localparam int NUM_SYS         = 5;
    localparam int SYS_ANALOG      = 0;
    localparam int SYS_DIGITAL     = 1;
    localparam int SYS_DAC         = 2;
    localparam int SYS_ANALOG_EXT  = 3;
    localparam int SYS_DIGITAL_EXT = 4;

    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_POLY = 32'hedb88320;

    // timing
    localparam int CLK_HZ          = 20_000_000;
    localparam int CRC_MIN_MS      = 5;
    localparam int CRC_MAX_MS      = 15;
    localparam int CRC_MIN_CYCLES  = CRC_MIN_MS * (CLK_HZ / 1000);
    localparam int WIPE_TIME_MS    = 3000;
    localparam int WIPE_CYCLES     = WIPE_TIME_MS * (CLK_HZ / 1000);
    localparam int BLINK_MS        = 250;
    localparam int BLINK_CYCLES    = BLINK_MS * (CLK_HZ / 1000);

    typedef enum { ST_IDLE, ST_COPY, ST_CRC, ST_WIPE } op_state_e;

    typedef enum logic [2:0] {
        OP_NONE, OP_SAVE_LIVE, OP_SAVE_FACT, OP_LOAD_FACT, OP_LOAD_SAVED,
        OP_WIPE
    } op_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } reg_rsp_s;

endpackage : io_config_pkg

// >>> testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
    import io_config_pkg::*;
    localparam int CRC_N  = 4;
    localparam int WIPE_N = 20;
    localparam int W      = NUM_SYS * 32;

    logic           clk;
    logic           rst;
    reg_req_s       req;
    reg_rsp_s       rsp;
    logic           live_wr;
    logic [2:0]     live_sel;
    logic [31:0]    live_wdata;
    logic [W-1:0]   live_cfg;
    logic [W-1:0]   factory_cfg;
    logic           wdog_timeout;
    logic [31:0]    wdog_advanced;
    logic           wipe_fail;
    logic           wireless_off;
    logic           user_clear;
    logic [1:0]     led;
    logic [W-1:0]   live_m;
    logic [W-1:0]   saved_m;
    int             error_cnt;
    int             n_tests;
    int             cyc = 0;

    io_config_store_manager #(.CRC_CYCLES(CRC_N), .WIPE_LEN(WIPE_N),
        .BLINK_LEN(3), .QUEUE_DEPTH(4)) i_dut (
        .clk(clk), .rst(rst), .req(req), .rsp(rsp), .live_wr(live_wr),
        .live_sel(live_sel), .live_wdata(live_wdata), .live_cfg(live_cfg),
        .factory_cfg(factory_cfg), .wdog_timeout(wdog_timeout),
        .wdog_advanced(wdog_advanced), .wipe_fail(wipe_fail),
        .wireless_off(wireless_off), .user_clear(user_clear), .led(led));

    always #25 clk = ~clk;

    // generous ceiling: the whole sequence needs well under 2000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (error_cnt == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // only analog, analog extended and digital extended words are summed
    function automatic logic [31:0] crc_exp(input logic [W-1:0] c);
        logic [31:0] r;
        int          base;
        r = CRC_INIT;
        for (int k = 0; k < 3; k++) begin
            base = (k == 0) ? SYS_ANALOG
                 : (k == 1) ? SYS_ANALOG_EXT : SYS_DIGITAL_EXT;
            r = r ^ c[base*32 +: 32];
            for (int b = 0; b < 32; b++)
                r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return ~r;
    endfunction : crc_exp

    task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
        @(negedge clk);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk);
        req.wr = 1'b0;
    endtask : wr_reg

    task automatic settle();
        repeat (4) @(negedge clk);
    endtask : settle

    task automatic edit_all();
        for (int i = 0; i < NUM_SYS; i++) begin
            @(negedge clk);
            live_wr = 1'b1;
            live_sel = 3'(i);
            live_wdata = $urandom;
            live_m[i*32 +: 32] = live_wdata;
            @(negedge clk);
            live_wr = 1'b0;
        end
    endtask : edit_all

    task automatic rd_crc(input logic [31:0] exp);
        int n;
        n = 0;
        @(negedge clk);
        req.rd = 1'b1;
        req.addr = ADDR_LIVE_CONFIG_CHECKSUM;
        @(negedge clk);
        req.rd = 1'b0;
        while (rsp.ack !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(W'(n), W'(CRC_N));
        check(W'(rsp.rdata), W'(exp));
    endtask : rd_crc

    task automatic wdog(input logic [31:0] opt);
        @(negedge clk);
        wdog_advanced = opt;
        wdog_timeout = 1'b1;
        @(negedge clk);
        wdog_timeout = 1'b0;
        settle();
    endtask : wdog

    initial begin
        int n;
        clk = 0; rst = 1; req = '0; live_wr = 0; live_sel = '0;
        live_wdata = '0; wdog_timeout = 0; wdog_advanced = '0;
        wipe_fail = 0; error_cnt = 0; n_tests = 0;
        void'($urandom(32'h0dc4618f));
        for (int i = 0; i < NUM_SYS; i++)
            factory_cfg[i*32 +: 32] = $urandom;
        live_m = '0;
        saved_m = '0;
        repeat (10) @(negedge clk);
        rst = 0;
        repeat (3) @(negedge clk);
        check(live_cfg, saved_m);
        check(W'({wireless_off, user_clear, led}), '0);
        for (int r = 0; r < 3; r++) begin
            edit_all();
            rd_crc(crc_exp(live_m));
        end
        wr_reg(ADDR_SAVE_DEFAULTS_FROM_LIVE, TRIGGER_ONE);
        saved_m = live_m;
        settle();
        edit_all();
        // values other than the exact trigger must do nothing
        wr_reg(ADDR_LOAD_LIVE_FROM_SAVED, 32'h00000002);
        wr_reg(ADDR_LOAD_LIVE_FROM_FACTORY, 32'h00000000);
        wr_reg(ADDR_WIPE_TRIGGER, WIPE_KEY ^ 32'h00000001);
        settle();
        check(live_cfg, live_m);
        check(W'(wireless_off), '0);
        wr_reg(ADDR_LOAD_LIVE_FROM_SAVED, TRIGGER_ONE);
        settle();
        check(live_cfg, saved_m);
        wr_reg(ADDR_LOAD_LIVE_FROM_FACTORY, TRIGGER_ONE);
        settle();
        check(live_cfg, factory_cfg);
        // back to back: the reload must see the new defaults
        edit_all();
        wr_reg(ADDR_SAVE_DEFAULTS_FROM_FACTORY, TRIGGER_ONE);
        wr_reg(ADDR_LOAD_LIVE_FROM_SAVED, TRIGGER_ONE);
        saved_m = factory_cfg;
        settle();
        check(live_cfg, factory_cfg);
        edit_all();
        wr_reg(ADDR_SAVE_DEFAULTS_FROM_LIVE, TRIGGER_ONE);
        saved_m = live_m;
        settle();
        edit_all();
        wdog(32'h00000002);
        check(live_cfg, saved_m);
        wdog(32'h00000001);
        check(live_cfg, factory_cfg);
        edit_all();
        wr_reg(ADDR_WIPE_TRIGGER, WIPE_KEY);
        repeat (2) @(negedge clk);
        check(W'(wireless_off), W'(1'b1));
        check(W'(led[0] ^ led[1]), W'(1'b1));
        n = 0;
        while (user_clear !== 1'b1 && n < WIPE_N + 10) begin
            @(negedge clk);
            n++;
        end
        check(W'(user_clear), W'(1'b1));
        settle();
        check(live_cfg, factory_cfg);
        check(W'(wireless_off), '0);
        wr_reg(ADDR_LOAD_LIVE_FROM_SAVED, TRIGGER_ONE);
        settle();
        check(live_cfg, factory_cfg);
        // failing wipe: unison blinking and no completion pulse
        wipe_fail = 1'b1;
        wr_reg(ADDR_WIPE_TRIGGER, WIPE_KEY);
        n = 0;
        repeat (WIPE_N + 10) begin
            @(negedge clk);
            if (user_clear === 1'b1)
                n++;
        end
        check(W'(n), '0);
        check(W'(led[0] ^ led[1]), '0);
        rst = 1'b1;
        wipe_fail = 1'b0;
        repeat (2) @(negedge clk);
        check(W'({wireless_off, user_clear, led}), '0);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check(live_cfg, '0);
        wrap_up();
    end
endmodule : testbench
